// ===== verilog/dram_pin_pkg.sv
// Shared constants for the dual-mode memory pin interface.
// Assumes a 16-bit external memory data bus and straps on its low byte.
`default_nettype none

package dram_pin_pkg;

    // ********************************************************
    // Bus widths and field positions
    // ********************************************************
    localparam int DATA_W = 16;
    localparam int ADDR_W = 11;
    localparam int COL_W = 8;
    localparam int ROW_W = 12;
    localparam int STRAP_W = 8;
    localparam int CMD_W = 4;
    localparam int A10_BIT = 10;
    localparam int MODE_BA_BIT = 11;
    localparam int STRAP_MEMTYPE_BIT = 1;
    localparam int SYNC_STAGES = 3;

    // ********************************************************
    // Request commands
    // ********************************************************
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_ACT = 4'h1;
    localparam logic [3:0] CMD_READ = 4'h2;
    localparam logic [3:0] CMD_WRITE = 4'h3;
    localparam logic [3:0] CMD_PRE = 4'h4;
    localparam logic [3:0] CMD_PRE_ALL = 4'h5;
    localparam logic [3:0] CMD_REFRESH = 4'h6;
    localparam logic [3:0] CMD_MODE = 4'h7;
    localparam logic [3:0] CMD_PDOWN = 4'h8;

    // ********************************************************
    // Pin codes, {select, row cmd, col cmd, write enable}, low active
    // ********************************************************
    localparam logic [3:0] PIN_NOP = 4'h7;
    localparam logic [3:0] PIN_ACT = 4'h3;
    localparam logic [3:0] PIN_READ = 4'h5;
    localparam logic [3:0] PIN_WRITE = 4'h4;
    localparam logic [3:0] PIN_PRE = 4'h2;
    localparam logic [3:0] PIN_REFRESH = 4'h1;
    localparam logic [3:0] PIN_MODE = 4'h0;
    localparam logic [3:0] PIN_DESELECT = 4'hf;

    // ********************************************************
    // Reset values and timing counts
    // ********************************************************
    localparam logic [1:0] PAIR_IDLE = 2'h3;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam int WAIT_TICKS_DEF = 4;

    function automatic logic [3:0] sdr_enc(input logic [3:0] cmd);
        case (cmd)
            CMD_NOP, CMD_PDOWN: sdr_enc = PIN_NOP;
            CMD_ACT: sdr_enc = PIN_ACT;
            CMD_READ: sdr_enc = PIN_READ;
            CMD_WRITE: sdr_enc = PIN_WRITE;
            CMD_PRE, CMD_PRE_ALL: sdr_enc = PIN_PRE;
            CMD_REFRESH: sdr_enc = PIN_REFRESH;
            CMD_MODE: sdr_enc = PIN_MODE;
            default: sdr_enc = PIN_DESELECT;
        endcase
    endfunction

endpackage

`default_nettype wire

// ===== verilog/dram_sync.sv
// Three-stage synchroniser for a group of levels.
// Assumes the group changes rarely; stable marks stages two and three agreeing.
`timescale 1ns/1ps
`default_nettype none

module dram_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic stable
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    initial begin
        if (W < 1) begin
            $error("dram_sync width must be at least one");
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign q = s3_q;
    assign stable = (s2_q == s3_q);

endmodule

`default_nettype wire

// ===== verilog/dram_pin_interface_dual_mode.sv
// Pin interface of the memory controller toward EDO DRAM or SDRAM.
// Assumes a request source on sys_clk and a free-running link clock mem_clk.
`timescale 1ns/1ps
`default_nettype none

module dram_pin_interface_dual_mode
    import dram_pin_pkg::*;
#(
    parameter int WAIT_TICKS = WAIT_TICKS_DEF
) (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link clock
    input wire logic mem_clk,
    // Request side
    input wire logic req_valid,
    input wire logic [CMD_W-1:0] req_cmd,
    input wire logic req_sel,
    input wire logic req_bank,
    input wire logic [ROW_W-1:0] req_row,
    input wire logic [COL_W-1:0] req_col,
    input wire logic req_auto_pre,
    input wire logic [1:0] req_be,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // Latched configuration
    output logic cfg_valid,
    output logic cfg_sdram,
    output logic [STRAP_W-1:0] cfg_straps,
    // Memory data bus
    input wire logic [DATA_W-1:0] mem_data_bus_in,
    output logic [DATA_W-1:0] mem_data_bus_out,
    output logic mem_data_bus_oe,
    // Memory control pins
    output logic [ADDR_W-1:0] mem_addr_bus,
    output logic mem_bank,
    output logic [1:0] mem_sel_n,
    output logic [1:0] mem_strobe_n,
    output logic mem_oe_cke,
    output logic mem_we_n,
    output logic sdr_row_cmd_n,
    output logic sdr_col_cmd_n,
    output logic sdr_mem_clock
);

    initial begin
        if (WAIT_TICKS < 2 || WAIT_TICKS > 15) begin
            $error("WAIT_TICKS must lie between 2 and 15");
        end
    end

    // ********************************************************
    // System domain: reset, straps and request hold
    // ********************************************************
    logic rs1_q, rs2_q, srst_n;
    logic [STRAP_W-1:0] strap_s;
    logic strap_ok;
    logic [1:0] settle_q;
    logic cfg_valid_q, cfg_sdram_q;
    logic [STRAP_W-1:0] cfg_straps_q;
    logic [CMD_W-1:0] cmd_h_q;
    logic sel_h_q, bank_h_q, auto_h_q, req_tgl_q, ack_last_q;
    logic [ROW_W-1:0] row_h_q;
    logic [COL_W-1:0] col_h_q;
    logic [1:0] be_h_q;
    logic [DATA_W-1:0] wdata_h_q, rsp_rdata_q, rd_data_q;
    logic req_ready_q, rsp_valid_q, ack_tgl_q, ack_s, ack_ok;
    wire strap_take = !cfg_valid_q && settle_q == STRAP_SETTLE && strap_ok;
    wire take = req_valid && req_ready_q;
    wire ack_seen = ack_ok && (ack_s != ack_last_q);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) {rs1_q, rs2_q} <= 2'b00;
        else {rs1_q, rs2_q} <= {1'b1, rs1_q};
    end
    assign srst_n = rs2_q;

    dram_sync #(.W(STRAP_W)) u_strap_sync (
        .clk(sys_clk), .rst_n(srst_n), .d(mem_data_bus_in[STRAP_W-1:0]),
        .q(strap_s), .stable(strap_ok)
    );
    dram_sync #(.W(1)) u_ack_sync (
        .clk(sys_clk), .rst_n(srst_n), .d(ack_tgl_q), .q(ack_s), .stable(ack_ok)
    );

    // The straps are caught once, after the synchroniser has filled.
    always_ff @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
            {settle_q, cfg_valid_q, cfg_sdram_q, cfg_straps_q} <= '0;
        end else begin
            if (settle_q != STRAP_SETTLE) settle_q <= settle_q + 2'h1;
            if (strap_take) {cfg_valid_q, cfg_straps_q, cfg_sdram_q} <=
                {1'b1, strap_s, strap_s[STRAP_MEMTYPE_BIT]};
        end
    end

    // Request fields are held stable until the link side answers.
    always_ff @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
            {cmd_h_q, sel_h_q, bank_h_q, row_h_q, col_h_q} <= '0;
            {auto_h_q, be_h_q, wdata_h_q, req_tgl_q} <= '0;
            {ack_last_q, rsp_valid_q, rsp_rdata_q, req_ready_q} <= '0;
        end else begin
            rsp_valid_q <= ack_seen;
            if (strap_take) req_ready_q <= 1'b1;
            if (take) begin
                {cmd_h_q, sel_h_q, bank_h_q, row_h_q} <= {req_cmd, req_sel, req_bank, req_row};
                {col_h_q, auto_h_q, be_h_q} <= {req_col, req_auto_pre, req_be};
                {wdata_h_q, req_tgl_q, req_ready_q} <= {req_wdata, ~req_tgl_q, 1'b0};
            end
            if (ack_seen) {ack_last_q, rsp_rdata_q, req_ready_q} <= {ack_s, rd_data_q, 1'b1};
        end
    end

    assign req_ready = req_ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rsp_rdata_q;
    assign cfg_valid = cfg_valid_q;
    assign cfg_sdram = cfg_sdram_q;
    assign cfg_straps = cfg_straps_q;

    // ********************************************************
    // Link domain: crossing and step sequencer
    // ********************************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ROW = 5'b00010,
        ST_COL = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_ACK = 5'b10000
    } step_e;

    step_e st_q, st_d;
    logic mr1_q, mr2_q, mrst_n;
    logic [2:0] ms;
    logic ms_ok, live_q, sdr_q, req_last_q, phase_q;
    logic [3:0] cnt_q;
    logic [DATA_W-1:0] dat_s;

    always_ff @(posedge mem_clk or negedge nrst) begin
        if (!nrst) {mr1_q, mr2_q} <= 2'b00;
        else {mr1_q, mr2_q} <= {1'b1, mr1_q};
    end
    assign mrst_n = mr2_q;

    dram_sync #(.W(3)) u_cfg_sync (
        .clk(mem_clk), .rst_n(mrst_n), .d({cfg_valid_q, cfg_sdram_q, req_tgl_q}),
        .q(ms), .stable(ms_ok)
    );
    dram_sync #(.W(DATA_W)) u_data_sync (
        .clk(mem_clk), .rst_n(mrst_n), .d(mem_data_bus_in), .q(dat_s), .stable()
    );

    // One step is one memory clock period; pins change as the clock falls.
    wire tick = phase_q;
    wire is_rd = cmd_h_q == CMD_READ;
    wire is_wr = cmd_h_q == CMD_WRITE;
    wire is_rw = is_rd || is_wr;
    wire [3:0] enc = sdr_enc(cmd_h_q);
    wire new_req = live_q && ms_ok && ms[0] != req_last_q;
    wire go_row = tick && st_q == ST_ROW ? 1'b0 : tick && st_q == ST_IDLE && new_req;
    wire go_col = tick && st_q == ST_ROW && !sdr_q && is_rw;
    wire row_out = tick && st_q == ST_ROW && !go_col;
    wire end_wait = tick && st_q == ST_WAIT && cnt_q == 4'h0;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: if (go_row) st_d = ST_ROW;
            ST_ROW: if (go_col) st_d = ST_COL; else if (row_out) st_d = ST_WAIT;
            ST_COL: if (tick) st_d = ST_WAIT;
            ST_WAIT: if (end_wait) st_d = ST_ACK;
            ST_ACK: if (tick) st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    // The memory type is frozen once, so every shared pin changes role together.
    always_ff @(posedge mem_clk or negedge mrst_n) begin
        if (!mrst_n) begin
            st_q <= ST_IDLE;
            {live_q, sdr_q, req_last_q, phase_q, ack_tgl_q} <= '0;
            {cnt_q, rd_data_q} <= '0;
        end else begin
            st_q <= st_d;
            phase_q <= ~phase_q;
            if (!live_q && ms_ok && ms[2]) {live_q, sdr_q} <= {1'b1, ms[1]};
            if (go_row) req_last_q <= ms[0];
            if (st_d == ST_WAIT && st_q != ST_WAIT) cnt_q <= 4'(WAIT_TICKS - 1);
            else if (tick && st_q == ST_WAIT && cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
            if (end_wait && is_rd) rd_data_q <= dat_s;
            if (tick && st_q == ST_ACK) ack_tgl_q <= ~ack_tgl_q;
        end
    end

    // ********************************************************
    // Link domain: pin values
    // ********************************************************
    logic [ADDR_W-1:0] addr_q, addr_d, row_addr;
    logic [1:0] sel_n_q, sel_n_d, strobe_n_q, strobe_n_d, sel_mask_n;
    logic bank_q, bank_d, oe_cke_q, oe_cke_d, we_n_q, we_n_d;
    logic rcmd_q, rcmd_d, ccmd_q, ccmd_d, clk_q, doe_q, doe_d;
    logic [DATA_W-1:0] dout_q, dout_d;

    assign sel_mask_n = req_sel_mask(sel_h_q);
    function automatic logic [1:0] req_sel_mask(input logic s);
        req_sel_mask = s ? 2'b01 : 2'b10;
    endfunction

    // Column on bits 7:0 with bit 10 for auto precharge; bit 10 for all banks.
    assign row_addr =
        (sdr_q && is_rw) ? {auto_h_q, 2'b00, col_h_q} :
        (sdr_q && cmd_h_q == CMD_PRE_ALL) ? 11'h400 :
        (sdr_q && cmd_h_q == CMD_PRE) ? 11'h000 :
        row_h_q[ADDR_W-1:0];
    assign sel_n_d =
        go_row ? (sdr_q ? (enc[3] ? PAIR_IDLE : sel_mask_n)
                        : (is_rw ? sel_mask_n : PAIR_IDLE)) :
        ((row_out && sdr_q) || end_wait) ? PAIR_IDLE : sel_n_q;
    assign strobe_n_d =
        go_row ? ((sdr_q && is_rw) ? ~be_h_q : PAIR_IDLE) :
        go_col ? ~be_h_q :
        end_wait ? PAIR_IDLE : strobe_n_q;
    assign we_n_d =
        go_row ? (sdr_q ? enc[0] : 1'b1) :
        go_col ? ~is_wr :
        (row_out || end_wait) ? 1'b1 : we_n_q;
    assign rcmd_d = (go_row && sdr_q) ? enc[2] :
        (row_out || end_wait) ? 1'b1 : rcmd_q;
    assign ccmd_d = (go_row && sdr_q) ? enc[1] :
        (row_out || end_wait) ? 1'b1 : ccmd_q;
    assign oe_cke_d =
        (go_row && sdr_q) ? (cmd_h_q != CMD_PDOWN) :
        (go_col && !sdr_q) ? is_wr :
        (end_wait && !sdr_q) ? 1'b1 : oe_cke_q;
    assign addr_d = go_row ? row_addr : go_col ? {3'b000, col_h_q} : addr_q;
    assign bank_d = (go_row && sdr_q) ?
        (cmd_h_q == CMD_MODE ? row_h_q[MODE_BA_BIT] : bank_h_q) : bank_q;
    assign doe_d = ((go_row && sdr_q) || go_col) ? is_wr :
        (row_out || end_wait) ? 1'b0 : doe_q;
    assign dout_d = (go_row || go_col) ? wdata_h_q : dout_q;

    always_ff @(posedge mem_clk or negedge mrst_n) begin
        if (!mrst_n) begin
            {sel_n_q, strobe_n_q} <= {PAIR_IDLE, PAIR_IDLE};
            {oe_cke_q, we_n_q, rcmd_q, ccmd_q} <= 4'hf;
            {bank_q, clk_q, doe_q} <= 3'h0;
            addr_q <= '0;
            dout_q <= '0;
        end else begin
            {sel_n_q, strobe_n_q, bank_q} <= {sel_n_d, strobe_n_d, bank_d};
            {oe_cke_q, we_n_q, rcmd_q, ccmd_q} <= {oe_cke_d, we_n_d, rcmd_d, ccmd_d};
            {addr_q, doe_q, dout_q} <= {addr_d, doe_d, dout_d};
            clk_q <= sdr_q & ~phase_q;
        end
    end

    assign mem_addr_bus = addr_q;
    assign mem_bank = bank_q;
    assign mem_sel_n = sel_n_q;
    assign mem_strobe_n = strobe_n_q;
    assign mem_oe_cke = oe_cke_q;
    assign mem_we_n = we_n_q;
    assign sdr_row_cmd_n = rcmd_q;
    assign sdr_col_cmd_n = ccmd_q;
    assign sdr_mem_clock = clk_q;
    assign mem_data_bus_out = dout_q;
    assign mem_data_bus_oe = doe_q;

    // ********************************************************
    // Checks
    // ********************************************************
    sequence s_issue(logic [3:0] c);
        go_row && sdr_q && cmd_h_q == c;
    endsequence
    sequence s_edo_col;
        go_col && !sdr_q;
    endsequence

    strap_latch_a: assert property (@(posedge sys_clk) disable iff (!srst_n)
        $rose(cfg_valid_q) |-> cfg_sdram_q == $past(strap_s[STRAP_MEMTYPE_BIT]))
        else $error("memory type not taken from strap");
    mode_frozen_a: assert property (@(posedge mem_clk) disable iff (!mrst_n)
        live_q && $past(live_q) |-> $stable(sdr_q))
        else $error("memory type changed after latch");
    edo_idle_a: assert property (@(posedge mem_clk) disable iff (!mrst_n)
        !sdr_q |-> rcmd_q && ccmd_q && !bank_q && !clk_q)
        else $error("sdram pins active in edo mode");
    sdr_clock_a: assert property (@(posedge mem_clk) disable iff (!mrst_n)
        sdr_q && $past(sdr_q) && $past(sdr_q, 2) |-> clk_q != $past(clk_q))
        else $error("memory clock not toggling");
    write_code_a: assert property (@(posedge mem_clk) disable iff (!mrst_n)
        s_issue(CMD_WRITE) |=> !sel_n_q[sel_h_q] && rcmd_q && !ccmd_q && !we_n_q
        ##2 sel_n_q == PAIR_IDLE && !doe_q)
        else $error("write command code wrong");
    read_col_a: assert property (@(posedge mem_clk) disable iff (!mrst_n)
        s_issue(CMD_READ) |=> addr_q[COL_W-1:0] == col_h_q
        && addr_q[A10_BIT] == auto_h_q && strobe_n_q == ~be_h_q)
        else $error("read column or mask wrong");
    pre_all_a: assert property (@(posedge mem_clk) disable iff (!mrst_n)
        s_issue(CMD_PRE_ALL) |=> addr_q[A10_BIT] && !rcmd_q && !we_n_q)
        else $error("precharge all bit not set");
    bank_sel_a: assert property (@(posedge mem_clk) disable iff (!mrst_n)
        s_issue(CMD_ACT) |=> bank_q == bank_h_q && !sel_n_q[sel_h_q])
        else $error("bank or select wrong on activate");
    mode_bank_a: assert property (@(posedge mem_clk) disable iff (!mrst_n)
        s_issue(CMD_MODE) |=> bank_q == row_h_q[MODE_BA_BIT] && sel_n_q != PAIR_IDLE)
        else $error("mode bit eleven not on bank pin");
    pdown_entry_a: assert property (@(posedge mem_clk) disable iff (!mrst_n)
        s_issue(CMD_PDOWN) |=> !oe_cke_q && sel_n_q != PAIR_IDLE && rcmd_q && ccmd_q && we_n_q
        ##1 !oe_cke_q)
        else $error("power-down not entered with no-op");
    edo_strobe_a: assert property (@(posedge mem_clk) disable iff (!mrst_n)
        s_edo_col |=> (strobe_n_q == ~be_h_q && oe_cke_q == is_wr) [*4])
        else $error("edo column strobes not held");

endmodule

`default_nettype wire

// ===== tb/mem_chip_model.sv
// Behavioural memory chip at the far side of the dual-mode pin interface.
// Assumes strap resistors on the low data byte; both selects share one array.
`timescale 1ns/1ps
`default_nettype none

module mem_chip_model (
    // Mode straps and clocks
    input wire logic mem_clk,
    input wire logic sclk,
    input wire logic [7:0] strap,
    // Controller pins
    input wire logic [10:0] addr,
    input wire logic bank,
    input wire logic [1:0] sel_n,
    input wire logic [1:0] strobe_n,
    input wire logic oe_cke,
    input wire logic we_n,
    input wire logic row_n,
    input wire logic col_n,
    input wire logic [15:0] din,
    // Chip data and last command seen
    output logic [15:0] dout,
    output logic [1:0] seen_sel_n,
    output logic [2:0] seen_code,
    output logic [10:0] seen_addr,
    output logic seen_bank,
    output logic [1:0] seen_mask
);
    logic [15:0] mem [512];
    logic [15:0] q;
    logic drv = 1'b0;
    logic tog = 1'b0;
    logic [1:0] lat = 2'h0;
    wire logic [15:0] idle = {tog ? 8'ha5 : 8'h5a, strap};
    wire logic edo_rd = !strap[1] && !oe_cke && we_n && sel_n != 2'b11;
    wire logic [1:0] act = {2{strap[1] ? drv : edo_rd}} & ~strobe_n;
    wire logic [15:0] src = strap[1] ? q : mem[{1'b0, addr[7:0]}];

    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
    end

    // Released bytes show a changing pattern, the low byte its pull level.
    assign dout = {act[1] ? src[15:8] : idle[15:8], act[0] ? src[7:0] : idle[7:0]};

    always @(posedge mem_clk) begin
        tog <= ~tog;
        if (!strap[1] && sel_n != 2'b11 && strobe_n != 2'b11) begin
            seen_sel_n <= sel_n;
            seen_mask <= strobe_n;
            for (int b = 0; b < 2; b++) begin
                if (!we_n && !strobe_n[b]) mem[{1'b0, addr[7:0]}][8*b +: 8] <= din[8*b +: 8];
            end
        end
    end

    // Read data comes two clock rises after the command and holds until the next one.
    always @(posedge sclk) begin
        if (lat != 2'h0) lat <= lat - 2'h1;
        if (lat == 2'h1) drv <= 1'b1;
        if (oe_cke && sel_n != 2'b11) begin
            seen_sel_n <= sel_n;
            seen_code <= {row_n, col_n, we_n};
            seen_addr <= addr;
            seen_bank <= bank;
            seen_mask <= strobe_n;
            drv <= 1'b0;
            if ({row_n, col_n, we_n} == 3'b101) begin
                q <= mem[{bank, addr[7:0]}];
                lat <= 2'h2;
            end
            for (int b = 0; b < 2; b++) begin
                if ({row_n, col_n, we_n} == 3'b100 && !strobe_n[b]) begin
                    mem[{bank, addr[7:0]}][8*b +: 8] <= din[8*b +: 8];
                end
            end
        end
    end
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the dual-mode memory pin interface.
// Assumes the memory chip model on the far side and both clocks made here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: got %h expected %h", $time, (a), (b)); end end

module testbench
    import dram_pin_pkg::*;
();
    logic sys_clk = 1'b0;
    logic mem_clk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    logic [CMD_W-1:0] req_cmd = '0;
    logic req_sel = 1'b0;
    logic req_bank = 1'b0;
    logic [ROW_W-1:0] req_row = '0;
    logic [COL_W-1:0] req_col = '0;
    logic req_auto_pre = 1'b0;
    logic [1:0] req_be = 2'h0;
    logic [DATA_W-1:0] req_wdata = '0;
    logic [STRAP_W-1:0] strap = 8'hff;
    logic req_ready, rsp_valid, cfg_valid, cfg_sdram, mem_data_bus_oe, mem_bank, mem_oe_cke;
    logic mem_we_n, sdr_row_cmd_n, sdr_col_cmd_n, sdr_mem_clock, seen_bank;
    logic [DATA_W-1:0] rsp_rdata, mem_data_bus_in, mem_data_bus_out, chip_dq;
    logic [STRAP_W-1:0] cfg_straps;
    logic [ADDR_W-1:0] mem_addr_bus, seen_addr;
    logic [1:0] mem_sel_n, mem_strobe_n, seen_sel_n, seen_mask;
    logic [2:0] seen_code;
    logic [15:0] exp_mem [512];
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #50 sys_clk = ~sys_clk;
    initial begin
        #13;
        forever #40 mem_clk = ~mem_clk;
    end

    assign mem_data_bus_in = mem_data_bus_oe ? mem_data_bus_out : chip_dq;

    dram_pin_interface_dual_mode #(.WAIT_TICKS(6)) dram_pin_interface_dual_mode_inst (
        .sys_clk, .nrst, .mem_clk, .req_valid, .req_cmd, .req_sel, .req_bank, .req_row,
        .req_col, .req_auto_pre, .req_be, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
        .cfg_valid, .cfg_sdram, .cfg_straps, .mem_data_bus_in, .mem_data_bus_out,
        .mem_data_bus_oe, .mem_addr_bus, .mem_bank, .mem_sel_n, .mem_strobe_n, .mem_oe_cke,
        .mem_we_n, .sdr_row_cmd_n, .sdr_col_cmd_n, .sdr_mem_clock);

    mem_chip_model mem_chip_model_inst (
        .mem_clk, .sclk(sdr_mem_clock), .strap, .addr(mem_addr_bus), .bank(mem_bank),
        .sel_n(mem_sel_n), .strobe_n(mem_strobe_n), .oe_cke(mem_oe_cke), .we_n(mem_we_n),
        .row_n(sdr_row_cmd_n), .col_n(sdr_col_cmd_n), .din(mem_data_bus_out), .dout(chip_dq),
        .seen_sel_n, .seen_code, .seen_addr, .seen_bank, .seen_mask);

    function automatic logic [2:0] exp_code(input logic [3:0] c);
        case (c)
            CMD_ACT: exp_code = 3'b011;
            CMD_READ: exp_code = 3'b101;
            CMD_WRITE: exp_code = 3'b100;
            CMD_PRE, CMD_PRE_ALL: exp_code = 3'b010;
            CMD_REFRESH: exp_code = 3'b001;
            CMD_MODE: exp_code = 3'b000;
            default: exp_code = 3'b111;
        endcase
    endfunction

    task automatic finish_test;
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic req(input logic [3:0] c, input logic s, input logic b,
            input logic [11:0] r, input logic [7:0] col, input logic ap,
            input logic [1:0] be, input logic [15:0] wd, output logic [15:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        {req_cmd, req_sel, req_bank, req_row, req_col, req_auto_pre, req_be, req_wdata} <=
            {c, s, b, r, col, ap, be, wd};
        do begin
            @(posedge sys_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 500);
        req_valid <= 1'b0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 1000);
        rd = rsp_rdata;
        if (n >= 1000) begin
            fail_count++;
            $display("Error %0t: request not answered", $time);
        end
    endtask

    task automatic do_reset(input logic sdr);
        int n;
        n = 0;
        strap <= {6'($urandom), sdr, 1'($urandom)};
        nrst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        `CHK({mem_sel_n, mem_strobe_n, mem_we_n, mem_data_bus_oe}, 6'h3e)
        nrst <= 1'b1;
        while (cfg_valid !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(cfg_sdram, sdr)
        `CHK(cfg_straps, strap)
    endtask

    task automatic cmd_pass;
        logic [3:0] cmds [10] = '{CMD_ACT, CMD_WRITE, CMD_READ, CMD_PRE, CMD_PRE_ALL,
            CMD_REFRESH, CMD_MODE, CMD_NOP, CMD_PDOWN, CMD_NOP};
        logic [15:0] rd;
        logic [11:0] r;
        logic [7:0] col;
        logic s, b, ap;
        logic [1:0] be;
        foreach (cmds[i]) begin
            {r, col, s, b, ap} = 23'($urandom);
            be = 2'($urandom_range(1, 3));
            req(cmds[i], s, b, r, col, ap, be, 16'h0, rd);
            if (cmds[i] == CMD_PDOWN) begin
                `CHK(mem_oe_cke, 1'b0)
            end else begin
                `CHK(mem_oe_cke, 1'b1)
                `CHK(seen_sel_n, ~(2'b01 << s))
                `CHK(seen_code, exp_code(cmds[i]))
            end
            if (cmds[i] inside {CMD_READ, CMD_WRITE}) begin
                `CHK(seen_addr, {ap, 2'b00, col})
                `CHK(seen_mask, ~be)
            end
            if (cmds[i] inside {CMD_PRE, CMD_PRE_ALL}) begin
                `CHK(seen_addr[A10_BIT], cmds[i] == CMD_PRE_ALL)
            end
            if (cmds[i] inside {CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_MODE}) begin
                `CHK(seen_bank, cmds[i] == CMD_MODE ? r[11] : b)
            end
        end
    endtask

    task automatic data_pass(input logic sdr);
        logic [15:0] rd, wd, m;
        logic [8:0] ix;
        logic [1:0] be;
        for (int i = 0; i < 8; i++) begin
            {ix, wd} = 25'($urandom);
            ix[8] = ix[8] & sdr;
            be = (i == 0) ? 2'b00 : 2'($urandom_range(1, 3));
            req(CMD_WRITE, wd[0], ix[8], 12'h0, ix[7:0], 1'b0, be, wd, rd);
            m = {{8{be[1]}}, {8{be[0]}}};
            exp_mem[ix] = (exp_mem[ix] & ~m) | (wd & m);
            be = 2'($urandom_range(1, 3));
            m = {{8{be[1]}}, {8{be[0]}}};
            req(CMD_READ, wd[1], ix[8], 12'h0, ix[7:0], 1'b0, be, 16'h0, rd);
            `CHK(rd & m, exp_mem[ix] & m)
            `CHK(seen_mask, ~be)
            `CHK(seen_sel_n, ~(2'b01 << wd[1]))
        end
    endtask

    // In the older memory mode the clock and the command pins stay idle.
    always @(posedge mem_clk) begin
        if (cfg_valid === 1'b1 && cfg_sdram === 1'b0) begin
            `CHK({sdr_mem_clock, sdr_row_cmd_n, sdr_col_cmd_n}, 3'b011)
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(32'h9fac4bb2));
        foreach (exp_mem[i]) exp_mem[i] = 16'h0000;
        do_reset(1'b1);
        cmd_pass();
        data_pass(1'b1);
        do_reset(1'b0);
        data_pass(1'b0);
        do_reset(1'b1);
        data_pass(1'b1);
        finish_test();
    end
endmodule

`default_nettype wire
